// ==== rtl/mii_port_pkg.sv ====
package mii_port_pkg;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int NIBBLE_W = 4;
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  // mdc divider: half period in system cycles (mdc = 25 MHz / 16)
  localparam int MDC_HALF_CYCLES = 8;
  // strap waits this many cycles after reset release, then is caught one cycle later
  localparam int STRAP_DELAY_CYCLES = 2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                en;
    logic [NIBBLE_W-1:0] data;
  } tx_nibble_type;

  typedef struct packed {
    logic                dv;
    logic                er;
    logic [NIBBLE_W-1:0] data;
  } rx_nibble_type;

  typedef struct packed {
    logic col;
    logic crs;
  } line_state_type;

  typedef enum logic [1:0] {
    STRAP_WAIT,
    STRAP_TAKE,
    STRAP_DONE
  } strap_state_type;

endpackage

// ==== rtl/external_mii_port_select.sv ====
// Notes on behaviour
// - txd driven, held zero for internal phy
// - tx_en only with valid nibble, else zero
// - select one: mdio active, mdc toggles
// - select zero: mdio released, mdc low
// - mdio strap captured as outside_phy_strap
module external_mii_port_select
  import mii_port_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        internal_phy_select,
  input  wire logic                        mgmt_port_select,
  input  wire mii_port_pkg::tx_nibble_type tx_in,
  input  wire logic                        mdio_out_in,
  input  wire logic                        mdio_drive_in,
  input  wire logic                        tx_clk,
  input  wire logic                        rx_clk,
  input  wire mii_port_pkg::rx_nibble_type rx_pin,
  input  wire mii_port_pkg::line_state_type line_pin,
  input  wire logic                        mdio_i,
  output logic [NIBBLE_W-1:0]              txd,
  output logic                             tx_en,
  output logic                             tx_taken,
  output mii_port_pkg::rx_nibble_type      rx_out,
  output logic                             rx_valid,
  output mii_port_pkg::line_state_type     line_out,
  output logic                             mdc,
  output logic                             mdio_o,
  output logic                             mdio_oe_n,
  output logic                             mdio_in_out,
  output logic                             outside_phy_strap
);
  import mii_port_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] txc_sync_reg, txc_sync_next;
  logic [2:0] rxc_sync_reg, rxc_sync_next;
  rx_nibble_type rx_s1_reg, rx_s2_reg;
  line_state_type line_s1_reg, line_s2_reg;
  logic [1:0] mdio_sync_reg;

  // first stage read only by second stage
  always_comb begin
    txc_sync_next = {txc_sync_reg[1:0], tx_clk};
    rxc_sync_next = {rxc_sync_reg[1:0], rx_clk};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      txc_sync_reg  <= 3'h0;
      rxc_sync_reg  <= 3'h0;
      rx_s1_reg     <= '0;
      rx_s2_reg     <= '0;
      line_s1_reg   <= '0;
      line_s2_reg   <= '0;
      mdio_sync_reg <= 2'h0;
    end else begin
      txc_sync_reg  <= txc_sync_next;
      rxc_sync_reg  <= rxc_sync_next;
      rx_s1_reg     <= rx_pin;
      rx_s2_reg     <= rx_s1_reg;
      line_s1_reg   <= line_pin;
      line_s2_reg   <= line_s1_reg;
      mdio_sync_reg <= {mdio_sync_reg[0], mdio_i};
    end
  end

  logic tx_fall, rx_rise;
  // edges found from stages two and three only
  assign tx_fall = txc_sync_reg[2] & ~txc_sync_reg[1];
  assign rx_rise = ~rxc_sync_reg[2] & rxc_sync_reg[1];

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  logic [NIBBLE_W-1:0] txd_reg, txd_next;
  logic tx_en_reg, tx_en_next, tx_taken_reg, tx_taken_next;

  // nibble changes on tx_clk fall so phy samples on rise
  always_comb begin
    txd_next      = txd_reg;
    tx_en_next    = tx_en_reg;
    tx_taken_next = 1'b0;
    if (internal_phy_select) begin
      txd_next   = NIBBLE_RST;
      tx_en_next = 1'b0;
    end else if (tx_fall) begin
      tx_en_next    = tx_in.en;
      txd_next      = tx_in.en ? tx_in.data : NIBBLE_RST;
      tx_taken_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      txd_reg      <= NIBBLE_RST;
      tx_en_reg    <= 1'b0;
      tx_taken_reg <= 1'b0;
    end else begin
      txd_reg      <= txd_next;
      tx_en_reg    <= tx_en_next;
      tx_taken_reg <= tx_taken_next;
    end
  end

  assign txd      = txd_reg;
  assign tx_en    = tx_en_reg;
  assign tx_taken = tx_taken_reg;

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  rx_nibble_type rx_out_reg, rx_out_next;
  logic rx_valid_reg, rx_valid_next;
  line_state_type line_reg;

  // nibble taken on every rx_clk rise, rx_valid set only with rx_dv
  always_comb begin
    rx_out_next   = rx_out_reg;
    rx_valid_next = 1'b0;
    if (rx_rise) begin
      rx_out_next   = rx_s2_reg;
      rx_valid_next = rx_s2_reg.dv;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_out_reg   <= '0;
      rx_valid_reg <= 1'b0;
      line_reg     <= '0;
    end else begin
      rx_out_reg   <= rx_out_next;
      rx_valid_reg <= rx_valid_next;
      line_reg     <= line_s2_reg;
    end
  end

  assign rx_out   = rx_out_reg;
  assign rx_valid = rx_valid_reg;
  assign line_out = line_reg;

  // ---------------------------------------------------------------
  // management port
  // ---------------------------------------------------------------
  logic [3:0] mdc_cnt_reg, mdc_cnt_next;
  logic mdc_reg, mdc_next, mdio_o_reg, mdio_o_next;
  logic mdio_oe_n_reg, mdio_oe_n_next, mdio_in_reg;

  // divider runs only while the port is selected
  always_comb begin
    mdc_cnt_next   = 4'h0;
    mdc_next       = 1'b0;
    mdio_o_next    = 1'b0;
    mdio_oe_n_next = 1'b1;
    if (mgmt_port_select) begin
      mdio_o_next    = mdio_out_in;
      mdio_oe_n_next = ~mdio_drive_in;
      mdc_next       = mdc_reg;
      mdc_cnt_next   = mdc_cnt_reg + 4'h1;
      if (mdc_cnt_reg == 4'(MDC_HALF_CYCLES - 1)) begin
        mdc_cnt_next = 4'h0;
        mdc_next     = ~mdc_reg;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mdc_cnt_reg   <= 4'h0;
      mdc_reg       <= 1'b0;
      mdio_o_reg    <= 1'b0;
      mdio_oe_n_reg <= 1'b1;
      mdio_in_reg   <= 1'b0;
    end else begin
      mdc_cnt_reg   <= mdc_cnt_next;
      mdc_reg       <= mdc_next;
      mdio_o_reg    <= mdio_o_next;
      mdio_oe_n_reg <= mdio_oe_n_next;
      mdio_in_reg   <= mdio_sync_reg[1];
    end
  end

  assign mdc         = mdc_reg;
  assign mdio_o      = mdio_o_reg;
  assign mdio_oe_n   = mdio_oe_n_reg;
  assign mdio_in_out = mdio_in_reg;

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  strap_state_type strap_state_reg, strap_state_next;
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic strap_reg, strap_next;

  // mdio level caught once, shortly after reset release
  always_comb begin
    strap_state_next = strap_state_reg;
    strap_cnt_next   = strap_cnt_reg;
    strap_next       = strap_reg;
    unique case (strap_state_reg)
      STRAP_WAIT: begin
        strap_cnt_next = strap_cnt_reg + 2'h1;
        if (strap_cnt_reg == 2'(STRAP_DELAY_CYCLES - 1)) begin
          strap_state_next = STRAP_TAKE;
        end
      end
      STRAP_TAKE: begin
        strap_next       = mdio_sync_reg[1];
        strap_state_next = STRAP_DONE;
      end
      STRAP_DONE: begin
        strap_state_next = STRAP_DONE;
      end
      default: begin
        strap_state_next = STRAP_DONE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      strap_state_reg <= STRAP_WAIT;
      strap_cnt_reg   <= 2'h0;
      strap_reg       <= 1'b0;
    end else begin
      strap_state_reg <= strap_state_next;
      strap_cnt_reg   <= strap_cnt_next;
      strap_reg       <= strap_next;
    end
  end

  assign outside_phy_strap = strap_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence tx_edge_seq;
    tx_fall && !internal_phy_select;
  endsequence

  txd_internal_a: assert property (@(posedge clock) disable iff (rst)
    internal_phy_select |=> txd == 4'h0 && !tx_en)
    else $error("tx outputs not parked for internal phy");
  tx_en_load_a: assert property (@(posedge clock) disable iff (rst)
    tx_edge_seq |=> tx_en == $past(tx_in.en) && tx_taken)
    else $error("tx_en not loaded on tx edge");
  txd_idle_a: assert property (@(posedge clock) disable iff (rst)
    !tx_en |-> txd == 4'h0)
    else $error("txd nonzero while tx_en low");
  tx_hold_a: assert property (@(posedge clock) disable iff (rst)
    !tx_fall && !internal_phy_select |=> $stable(txd))
    else $error("txd changed away from tx edge");
  rx_accept_a: assert property (@(posedge clock) disable iff (rst)
    rx_valid |-> rx_out.dv && $past(rx_rise))
    else $error("rx nibble accepted without rx_dv");
  mdc_parked_a: assert property (@(posedge clock) disable iff (rst)
    !mgmt_port_select |=> !mdc && mdio_oe_n)
    else $error("management port not parked");
  mdc_toggle_a: assert property (@(posedge clock) disable iff (rst)
    mgmt_port_select && mdc_cnt_reg == 4'(MDC_HALF_CYCLES - 1) |=>
    mdc != $past(mdc))
    else $error("mdc did not toggle");
  strap_take_a: assert property (@(posedge clock) disable iff (rst)
    strap_state_reg == STRAP_TAKE |=>
    outside_phy_strap == $past(mdio_sync_reg[1]))
    else $error("strap not captured");

endmodule

// ==== verif/mii_phy_model.sv ====
module mii_phy_model
  import mii_port_pkg::*;
(
  output logic                             tx_clk,
  output logic                             rx_clk,
  input  wire mii_port_pkg::rx_nibble_type rx_next,
  output mii_port_pkg::rx_nibble_type      rx_pin,
  input  wire logic                        strap_high,
  input  wire logic                        mdio_o,
  input  wire logic                        mdio_oe_n,
  output logic                             mdio_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // -------------------------------------------------------------
  // phy side of the link
  // -------------------------------------------------------------
  // free-running transmit and receive clocks, unrelated in phase
  initial begin
    tx_clk = 1'b0;
    rx_clk = 1'b0;
    fork
      forever #160 tx_clk = ~tx_clk;
      begin
        #93;
        forever #160 rx_clk = ~rx_clk;
      end
    join
  end

  // nibble launched on falling rx_clk; idle data churns every cycle
  initial rx_pin = 6'h00;
  always @(negedge rx_clk) begin
    if (rx_next.dv)
      rx_pin <= rx_next;
    else
      rx_pin <= {1'b0, rx_next.er, ~rx_pin.data};
  end

  // shared mdio wire: device drive, else strap resistor level
  assign mdio_pin = !mdio_oe_n ? mdio_o : strap_high;
endmodule

// ==== verif/test_external_mii_port_select.sv ====
module test_external_mii_port_select;
  timeunit 1ns;
  timeprecision 1ns;
  import mii_port_pkg::*;

  logic           clock, rst, int_sel, mgmt_sel, mdio_out_in, mdio_drive_in;
  logic           tx_clk, rx_clk, mdio_i, strap_high, got, prev;
  tx_nibble_type  tx_in, nib;
  rx_nibble_type  rx_next, rx_pin, rx_out, rxn, val;
  line_state_type line_pin, line_out;
  logic [3:0]     txd;
  logic           tx_en, tx_taken, rx_valid, mdc, mdio_o, mdio_oe_n;
  logic           mdio_in_out, outside_phy_strap;
  int             error_cnt, samples_checked, cycles, n;

  external_mii_port_select dut (.clock(clock), .rst(rst),
    .internal_phy_select(int_sel), .mgmt_port_select(mgmt_sel),
    .tx_in(tx_in), .mdio_out_in(mdio_out_in), .mdio_drive_in(mdio_drive_in),
    .tx_clk(tx_clk), .rx_clk(rx_clk), .rx_pin(rx_pin), .line_pin(line_pin),
    .mdio_i(mdio_i), .txd(txd), .tx_en(tx_en), .tx_taken(tx_taken),
    .rx_out(rx_out), .rx_valid(rx_valid), .line_out(line_out), .mdc(mdc),
    .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .mdio_in_out(mdio_in_out),
    .outside_phy_strap(outside_phy_strap));

  mii_phy_model phy (.tx_clk(tx_clk), .rx_clk(rx_clk), .rx_next(rx_next),
    .rx_pin(rx_pin), .strap_high(strap_high), .mdio_o(mdio_o),
    .mdio_oe_n(mdio_oe_n), .mdio_pin(mdio_i));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // expected {tx_en, txd} for a nibble and phy selection
  function automatic logic [4:0] tx_expect(tx_nibble_type t, logic sel);
    tx_expect = (sel || !t.en) ? 5'h00 : {1'b1, t.data};
  endfunction

  // system clock and hang guard
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    rst = 1'b1; int_sel = 1'b0; mgmt_sel = 1'b0; tx_in = 5'h00;
    mdio_out_in = 1'b0; mdio_drive_in = 1'b0; rx_next = 6'h00;
    line_pin = 2'h0; strap_high = 1'b1;
    void'($urandom(25));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock); #1;
    check("idle pins", 8'h01, {txd, tx_en, mdc, mdio_oe_n});
    repeat (10) @(posedge clock);
    strap_high <= 1'b0;
    #1 check("strap", 8'h01, outside_phy_strap);
    repeat (8) @(posedge clock); #1;
    check("strap held", 8'h01, outside_phy_strap);
    // transmit nibbles, some while the internal phy is selected
    for (int i = 0; i < 24; i++) begin
      @(posedge clock);
      nib = (i < 2) ? 5'h1F : 5'($urandom);
      tx_in <= nib;
      int_sel <= (i % 6 == 5);
      got = 1'b0;
      for (int k = 0; k < 20 && !got; k++) begin
        @(posedge clock); #1;
        got = (tx_taken === 1'b1);
      end
      check("tx_taken", !int_sel, got);
      check("tx_en txd", tx_expect(nib, int_sel), {tx_en, txd});
    end
    @(posedge clock);
    int_sel <= 1'b0;
    // receive nibbles with random valid, error and line state
    for (int i = 0; i < 24; i++) begin
      @(posedge rx_clk);
      @(posedge clock);
      rxn = (i < 2) ? 6'h3A : 6'($urandom);
      rx_next <= rxn;
      line_pin <= 2'($urandom);
      @(posedge rx_clk);
      got = 1'b0;
      for (int k = 0; k < 7; k++) begin
        @(posedge clock); #1;
        if (rx_valid === 1'b1) begin
          got = 1'b1;
          val = rx_out;
        end
      end
      check("rx_valid", rxn.dv, got);
      if (rxn.dv) check("rx_out", rxn, val);
      check("line_out", line_pin, line_out);
    end
    // management port on: every drive combination
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      mgmt_sel <= 1'b1;
      mdio_drive_in <= i[0];
      mdio_out_in <= i[1];
      repeat (3) @(posedge clock); #1;
      check("mdio_oe_n", !i[0], mdio_oe_n);
      if (i[0]) check("mdio_o", i[1], mdio_o);
      n = 0;
      prev = mdc;
      repeat (32) begin
        @(posedge clock); #1;
        if (mdc !== prev) n++;
        prev = mdc;
      end
      check("mdc toggles", 32 / MDC_HALF_CYCLES, n);
      check("mdio_in_out", i[0] & i[1], mdio_in_out);
    end
    // management port parked
    @(posedge clock);
    mgmt_sel <= 1'b0;
    repeat (2) @(posedge clock);
    repeat (20) begin
      @(posedge clock); #1;
      check("parked mdc oe_n", 8'h01, {mdc, mdio_oe_n});
    end
    final_report();
  end
endmodule
